// [inc/fl_pkg.sv]
package fl_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FLASH_DATA_W = 16;
    localparam int unsigned FLASH_ADDR_W = 23;
    localparam int unsigned SYNC_W = 17;
    localparam int unsigned CNT_W = 16;

    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] ADDR_OFF = 8'h04;
    localparam logic [7:0] WDATA_OFF = 8'h08;
    localparam logic [7:0] CMD_OFF = 8'h0c;
    localparam logic [7:0] RDATA_OFF = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_OFF = 8'h1c;
    localparam logic [7:0] IRQ_ENABLE_OFF = 8'h20;

    // Field positions
    localparam int unsigned CTRL_BYTE_MODE_BIT = 0;
    localparam int unsigned CTRL_PROTECT_BIT = 1;
    localparam int unsigned CTRL_BUSY_WRITE_BIT = 2;
    localparam int unsigned CMD_WRITE_BIT = 0;
    localparam int unsigned CMD_READ_BIT = 1;
    localparam int unsigned CMD_RESET_BIT = 2;
    localparam int unsigned CMD_WAIT_BIT = 3;
    localparam int unsigned STAT_ENGINE_BUSY_BIT = 0;
    localparam int unsigned STAT_DEV_READY_BIT = 1;
    localparam int unsigned STAT_TOGGLE_BIT = 2;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_READY_BIT = 1;
    localparam int unsigned IRQ_REFUSED_BIT = 2;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned TOGGLE_DQ_BIT = 6;
    localparam int unsigned READY_SYNC_BIT = 16;

    // Reset values
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [15:0] WDATA_RESET = 16'h0000;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

    // Timing, in ns, and derived cycle counts (least times round up)
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned T_SETUP_NS = 20;
    localparam int unsigned T_WE_PULSE_NS = 50;
    localparam int unsigned T_HOLD_NS = 20;
    localparam int unsigned T_ACCESS_NS = 120;
    localparam int unsigned T_RESET_PULSE_NS = 500;
    localparam int unsigned T_RECOVER_NS = 50000;
    localparam int unsigned SYNC_LAT_CYC = 4;
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WE_CYC = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT_CYC;
    localparam int unsigned RESET_CYC = (T_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RECOVER_CYC_DEFAULT = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_SETUP = 8'h02,
        ST_STROBE = 8'h04,
        ST_HOLD = 8'h08,
        ST_READ = 8'h10,
        ST_RESET = 8'h20,
        ST_RECOVER = 8'h40,
        ST_WAIT = 8'h80
    } fl_state_type;
endpackage : fl_pkg

// [inc/fl_sync_if.sv]
`timescale 1ns/1ns
interface fl_sync_if;
    logic [fl_pkg::SYNC_W-1:0] raw;
    logic [fl_pkg::SYNC_W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : fl_sync_if

// [core/fl_pin_sync.sv]
`timescale 1ns/1ns
module fl_pin_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pins in, filtered levels out
    fl_sync_if.sync port
);
    import fl_pkg::*;

    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic level;
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= port.raw[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            // A change counts only once the later two stages agree
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in) begin
                    level <= 1'b0;
                end else if (s2 == s3) begin
                    level <= s3;
                end
            end
            assign port.clean[i] = level;
        end
    endgenerate
endmodule : fl_pin_sync

// [core/fl_host_ctrl.sv]
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module fl_host_ctrl #(
    parameter int unsigned RECOVER_CYCLES = fl_pkg::RECOVER_CYC_DEFAULT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [fl_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [fl_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [fl_pkg::DATA_W-1:0] reg_rdata_out,
    output logic irq_out,
    // Flash pins
    output logic [fl_pkg::FLASH_ADDR_W-1:0] flash_addr_out,
    output logic [fl_pkg::FLASH_DATA_W-1:0] flash_data_out,
    output logic [fl_pkg::FLASH_DATA_W-1:0] flash_data_oe_out,
    input wire logic [fl_pkg::FLASH_DATA_W-1:0] flash_data_in,
    output logic chip_sel_n_out,
    output logic out_en_n_out,
    output logic write_n_out,
    output logic reset_n_out,
    output logic byte_n_out,
    output logic protect_accel_n_out,
    input wire logic ready_busy_in
);
    import fl_pkg::*;

    fl_state_type state;
    logic [CNT_W-1:0] count;
    logic byte_mode;
    logic protect;
    logic busy_write;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic toggle_seen;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic dev_ready;
    logic dev_ready_q;
    logic [15:0] pin_data;
    logic cmd_hit;
    logic go_write;
    logic go_read;
    logic go_reset;
    logic go_wait;
    logic refused;
    logic op_done;
    logic [15:0] next_rdata;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    fl_sync_if sync_bus ();
    // Ready enters inverted: the cleared synchroniser then reads as ready, so no false rise
    assign sync_bus.raw = {!ready_busy_in, flash_data_in};

    fl_pin_sync u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .port(sync_bus.sync)
    );

    assign pin_data = sync_bus.clean[15:0];
    assign dev_ready = !sync_bus.clean[READY_SYNC_BIT];

    // Command decode; only one action per command write, write wins
    assign cmd_hit = reg_wr_in && (reg_addr_in == CMD_OFF);
    // Program or erase writes are refused while not ready; suspend may override
    assign refused = cmd_hit && ((state != ST_IDLE) ||
        (reg_wdata_in[CMD_WRITE_BIT] && !dev_ready && !busy_write));
    assign go_write = cmd_hit && !refused && reg_wdata_in[CMD_WRITE_BIT];
    assign go_read = cmd_hit && !refused && !reg_wdata_in[CMD_WRITE_BIT] &&
        reg_wdata_in[CMD_READ_BIT];
    assign go_reset = cmd_hit && !refused && !reg_wdata_in[CMD_WRITE_BIT] &&
        !reg_wdata_in[CMD_READ_BIT] && reg_wdata_in[CMD_RESET_BIT];
    assign go_wait = cmd_hit && !refused && !reg_wdata_in[CMD_WRITE_BIT] &&
        !reg_wdata_in[CMD_READ_BIT] && !reg_wdata_in[CMD_RESET_BIT] &&
        reg_wdata_in[CMD_WAIT_BIT];

    assign op_done = (state == ST_HOLD || state == ST_READ || state == ST_RECOVER) &&
        (count == '0) || (state == ST_WAIT && dev_ready);
    // In byte mode only the low lane is meaningful
    assign next_rdata = byte_mode ? {8'h00, pin_data[7:0]} : pin_data;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            count <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go_write) begin
                        state <= ST_SETUP;
                        count <= CNT_W'(SETUP_CYC - 1);
                    end else if (go_read) begin
                        state <= ST_READ;
                        count <= CNT_W'(ACCESS_CYC - 1);
                    end else if (go_reset) begin
                        state <= ST_RESET;
                        count <= CNT_W'(RESET_CYC - 1);
                    end else if (go_wait) begin
                        state <= ST_WAIT;
                    end
                end
                ST_SETUP: begin
                    if (count == '0) begin
                        state <= ST_STROBE;
                        count <= CNT_W'(WE_CYC - 1);
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ST_STROBE: begin
                    if (count == '0) begin
                        state <= ST_HOLD;
                        count <= CNT_W'(HOLD_CYC - 1);
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ST_RESET: begin
                    if (count == '0) begin
                        state <= ST_RECOVER;
                        count <= CNT_W'(RECOVER_CYCLES - 1);
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ST_HOLD, ST_READ, ST_RECOVER: begin
                    if (count == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (dev_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    count <= '0;
                end
            endcase
        end
    end

    // Pins follow the state one cycle later, so every phase keeps its length
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            chip_sel_n_out <= 1'b1;
            out_en_n_out <= 1'b1;
            write_n_out <= 1'b1;
            reset_n_out <= 1'b1;
            flash_data_oe_out <= '0;
        end else begin
            chip_sel_n_out <= !(state == ST_SETUP || state == ST_STROBE ||
                state == ST_HOLD || state == ST_READ);
            out_en_n_out <= !(state == ST_READ);
            write_n_out <= !(state == ST_STROBE);
            reset_n_out <= !(state == ST_RESET);
            flash_data_oe_out[14:0] <= {15{state == ST_SETUP || state == ST_STROBE ||
                state == ST_HOLD}};
            // Top pin is an address input in byte mode, so it is driven always
            flash_data_oe_out[15] <= byte_mode || state == ST_SETUP ||
                state == ST_STROBE || state == ST_HOLD;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            flash_addr_out <= '0;
            flash_data_out <= '0;
            byte_n_out <= 1'b1;
            protect_accel_n_out <= 1'b1;
        end else begin
            flash_addr_out <= byte_mode ? addr_reg[23:1] : addr_reg[22:0];
            flash_data_out[14:0] <= wdata_reg[14:0];
            flash_data_out[15] <= byte_mode ? addr_reg[0] : wdata_reg[15];
            byte_n_out <= !byte_mode;
            protect_accel_n_out <= !protect;
        end
    end

    // Settings registers may change under an operation; pins then follow at once
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            byte_mode <= CTRL_RESET[CTRL_BYTE_MODE_BIT];
            protect <= CTRL_RESET[CTRL_PROTECT_BIT];
            busy_write <= CTRL_RESET[CTRL_BUSY_WRITE_BIT];
            addr_reg <= ADDR_RESET;
            wdata_reg <= WDATA_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                CTRL_OFF: begin
                    byte_mode <= reg_wdata_in[CTRL_BYTE_MODE_BIT];
                    protect <= reg_wdata_in[CTRL_PROTECT_BIT];
                    busy_write <= reg_wdata_in[CTRL_BUSY_WRITE_BIT];
                end
                ADDR_OFF: addr_reg <= reg_wdata_in[23:0];
                WDATA_OFF: wdata_reg <= reg_wdata_in[15:0];
                IRQ_ENABLE_OFF: irq_enable <= reg_wdata_in[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= '0;
            toggle_seen <= 1'b0;
        end else if (state == ST_READ && count == '0) begin
            rdata_reg <= next_rdata;
            toggle_seen <= next_rdata[TOGGLE_DQ_BIT] ^ rdata_reg[TOGGLE_DQ_BIT];
        end
    end

    assign irq_set = {refused, dev_ready && !dev_ready_q, op_done};
    assign irq_clr = (reg_wr_in && reg_addr_in == IRQ_CLEAR_OFF) ?
        reg_wdata_in[IRQ_W-1:0] : '0;

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dev_ready_q <= 1'b1;
            irq_status <= '0;
            irq_out <= 1'b0;
        end else begin
            dev_ready_q <= dev_ready;
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq_out <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                CTRL_OFF: reg_rdata_out <= {29'h0, busy_write, protect, byte_mode};
                ADDR_OFF: reg_rdata_out <= {8'h00, addr_reg};
                WDATA_OFF: reg_rdata_out <= {16'h0000, wdata_reg};
                RDATA_OFF: reg_rdata_out <= {16'h0000, rdata_reg};
                STATUS_OFF: reg_rdata_out <= {29'h0, toggle_seen, dev_ready,
                    state != ST_IDLE};
                IRQ_STATUS_OFF: reg_rdata_out <= {29'h0, irq_status};
                IRQ_ENABLE_OFF: reg_rdata_out <= {29'h0, irq_enable};
                default: reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end
endmodule : fl_host_ctrl

// [bench/fl_host_ctrl_asserts.sv]
`timescale 1ns/1ns
module fl_host_ctrl_asserts #(
    parameter int unsigned RECOVER_CYCLES = fl_pkg::RECOVER_CYC_DEFAULT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Flash pins
    input wire logic [fl_pkg::FLASH_ADDR_W-1:0] flash_addr_out,
    input wire logic [fl_pkg::FLASH_DATA_W-1:0] flash_data_out,
    input wire logic [fl_pkg::FLASH_DATA_W-1:0] flash_data_oe_out,
    input wire logic chip_sel_n_out,
    input wire logic out_en_n_out,
    input wire logic write_n_out,
    input wire logic reset_n_out,
    input wire logic byte_n_out,
    input wire logic irq_out
);
    import fl_pkg::*;
    logic [7:0] oe_cnt;
    logic [7:0] rst_cnt;
    int unsigned rec_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) oe_cnt <= 8'h00;
        else oe_cnt <= out_en_n_out ? 8'h00 : oe_cnt + 8'h01;
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) rst_cnt <= 8'h00;
        else rst_cnt <= reset_n_out ? 8'h00 : rst_cnt + 8'h01;
    end
    // Starts saturated so a block reset is not taken for a recovery
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) rec_cnt <= RECOVER_CYCLES;
        else if (!reset_n_out) rec_cnt <= 0;
        else if (rec_cnt < RECOVER_CYCLES) rec_cnt <= rec_cnt + 1;
    end
    chk_we_with_cs: assert property (!write_n_out |-> !chip_sel_n_out)
        else $error("strobe without select");
    chk_we_width: assert property ($fell(write_n_out) |-> !write_n_out [*5] ##1 write_n_out)
        else $error("strobe width wrong");
    chk_cs_setup: assert property ($fell(write_n_out) |-> $past(chip_sel_n_out, 2) == 1'h0)
        else $error("select setup short");
    chk_cs_hold: assert property ($rose(write_n_out) |->
        !chip_sel_n_out ##1 !chip_sel_n_out ##1 chip_sel_n_out) else $error("select hold wrong");
    chk_pins_steady: assert property (!write_n_out && !$past(write_n_out) |->
        $stable(flash_data_out) && $stable(flash_addr_out)) else $error("pins moved");
    chk_read_quiet: assert property (!out_en_n_out |-> write_n_out &&
        flash_data_oe_out[14:0] == 15'h0000) else $error("driving during read");
    chk_byte_top: assert property (!byte_n_out |-> flash_data_oe_out[15])
        else $error("top pin not driven");
    chk_read_len: assert property ($rose(out_en_n_out) |-> oe_cnt == 8'h10)
        else $error("read length wrong");
    chk_reset_len: assert property ($rose(reset_n_out) |-> rst_cnt == 8'h32)
        else $error("reset pulse wrong");
    chk_recover_idle: assert property (reset_n_out && rec_cnt < RECOVER_CYCLES |->
        chip_sel_n_out) else $error("access during recovery");
    cover property ($fell(write_n_out));
    cover property ($fell(out_en_n_out));
    cover property ($rose(reset_n_out));
    cover property (irq_out);
endmodule : fl_host_ctrl_asserts
bind fl_host_ctrl fl_host_ctrl_asserts #(.RECOVER_CYCLES(RECOVER_CYCLES))
    fl_host_ctrl_asserts_i (.*);

// [bench/fl_flash_model.sv]
`timescale 1ns/1ns
module fl_flash_model (
    // Pins from the controller
    input wire logic [22:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic write_n_in,
    input wire logic reset_n_in,
    input wire logic protect_accel_n_in,
    input wire logic byte_n_in,
    // Busy time and pins back
    input wire logic [15:0] busy_ns_in,
    output logic [15:0] data_out,
    output logic ready_busy_out
);
    logic [15:0] cmd_latch, word, rd_val, last;
    logic [15:0] mem [16];
    logic toggle, susp;
    logic [6:0] busy_sect;
    int busy_left;
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        cmd_latch = 16'h0000;
        last = 16'h0000;
        toggle = 1'h0;
        susp = 1'h0;
        busy_left = 0;
        busy_sect = 7'h00;
        ready_busy_out = 1'h1;
    end
    // Busy time only runs while not suspended
    always #10 begin
        if (!reset_n_in) begin
            busy_left = 0;
            susp = 1'h0;
        end else if (!susp && busy_left > 0) begin
            busy_left = busy_left - 10;
        end
        ready_busy_out = busy_left <= 0 || susp;
    end
    // A write while busy suspends or resumes instead of starting an operation
    always @(posedge write_n_in) begin
        if (!chip_sel_n_in && reset_n_in) begin
            if (busy_left > 0) begin
                susp = !susp;
            end else begin
                cmd_latch = data_in;
                if (protect_accel_n_in) mem[addr_in[3:0]] = mem[addr_in[3:0]] & data_in;
                busy_left = busy_ns_in;
                busy_sect = addr_in[22:16];
                ready_busy_out = 1'h0;
            end
        end
    end
    always @(negedge out_en_n_in) begin
        if (!ready_busy_out) toggle = !toggle;
    end
    assign word = mem[addr_in[3:0]];
    always_comb begin
        // The suspended sector keeps answering with status, not data
        if (!ready_busy_out || (susp && addr_in[22:16] == busy_sect))
            rd_val = {8'h00, ~cmd_latch[7], toggle, 6'h00};
        else if (byte_n_in) rd_val = word;
        else rd_val = {8'h00, data_in[15] ? word[15:8] : word[7:0]};
    end
    // Released pins show the inverse of the last value, never a held copy
    assign data_out = (!chip_sel_n_in && !out_en_n_in) ? rd_val : ~last;
    always @(posedge out_en_n_in) last = rd_val;
endmodule : fl_flash_model

// [bench/tb_fl_host_ctrl.sv]
`timescale 1ns/1ns
module tb_fl_host_ctrl;
    import fl_pkg::*;
`define CHK(nm, e, s) begin \
    checks++; \
    if ((s) !== (e)) begin \
        miscompares++; \
        $display("wrong value %s expected %h seen %h", nm, e, s); \
    end \
end
    logic clk_in, reset_in, reg_wr_in, reg_rd_in, irq_out;
    logic [7:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [22:0] flash_addr_out;
    logic [15:0] flash_data_out, flash_data_oe_out, flash_data_in, dev_data, busy_ns;
    logic chip_sel_n_out, out_en_n_out, write_n_out, reset_n_out, byte_n_out;
    logic protect_accel_n_out, ready_busy_in;
    logic [15:0] emem [16];
    logic [2:0] irq_en;
    int miscompares, checks;
    assign flash_data_in = (flash_data_oe_out & flash_data_out) | (~flash_data_oe_out & dev_data);
    fl_host_ctrl #(.RECOVER_CYCLES(4)) fl_host_ctrl_i (.*);
    fl_flash_model fl_flash_model_i (.addr_in(flash_addr_out), .data_in(flash_data_in),
        .chip_sel_n_in(chip_sel_n_out), .out_en_n_in(out_en_n_out), .write_n_in(write_n_out),
        .reset_n_in(reset_n_out), .protect_accel_n_in(protect_accel_n_out),
        .byte_n_in(byte_n_out), .busy_ns_in(busy_ns), .data_out(dev_data),
        .ready_busy_out(ready_busy_in));
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge clk_in);
        reg_wr_in <= 1'h0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge clk_in);
        reg_rd_in <= 1'h0;
        #1 d = reg_rdata_out;
    endtask : rd_reg
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic wait_irq(input int b);
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 3000 && s[b] !== 1'h1; i++) rd_reg(IRQ_STATUS_OFF, s);
        `CHK("event", 1'h1, s[b])
        `CHK("irq line", irq_en[b], irq_out)
        wr_reg(IRQ_CLEAR_OFF, 32'h1 << b);
        rd_reg(IRQ_STATUS_OFF, s);
        `CHK("cleared", 1'h0, s[b])
    endtask : wait_irq
    task automatic op(input int b, input logic [23:0] a, input logic [15:0] d);
        wr_reg(ADDR_OFF, {8'h00, a});
        wr_reg(WDATA_OFF, {16'h0000, d});
        wr_reg(CMD_OFF, 32'h1 << b);
    endtask : op
    task automatic prog(input logic [23:0] a, input logic [15:0] d);
        op(CMD_WRITE_BIT, a, d);
        emem[a[3:0]] = emem[a[3:0]] & d;
        wait_irq(IRQ_DONE_BIT);
    endtask : prog
    task automatic rd_word(input logic [23:0] a, output logic [31:0] v);
        op(CMD_READ_BIT, a, 16'h0000);
        wait_irq(IRQ_DONE_BIT);
        rd_reg(RDATA_OFF, v);
    endtask : rd_word
    function automatic logic [31:0] exp_rd(input logic [23:0] a, input logic bm);
        logic [15:0] w;
        w = emem[bm ? a[4:1] : a[3:0]];
        if (bm) return {24'h0, a[0] ? w[15:8] : w[7:0]};
        return {16'h0, w};
    endfunction : exp_rd
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    initial begin
        #800000;
        miscompares++;
        close_out;
    end
    initial begin
        logic [31:0] v;
        logic [23:0] a, a2;
        logic [15:0] d;
        reset_in = 1'h1;
        reg_wr_in = 1'h0;
        reg_rd_in = 1'h0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0;
        busy_ns = 16'h0bb8;
        irq_en = 3'h0;
        foreach (emem[i]) emem[i] = 16'hffff;
        void'($urandom(54));
        repeat (3) @(posedge clk_in);
        reset_in <= 1'h0;
        repeat (6) @(posedge clk_in);
        rd_reg(CTRL_OFF, v);
        `CHK("ctrl", 32'h0, v)
        rd_reg(8'hfc, v);
        `CHK("unmapped", 32'h0, v)
        rd_reg(STATUS_OFF, v);
        `CHK("idle status", 2'h2, v[1:0])
        a = {1'h0, 23'($urandom)};
        rd_word(a, v);
        `CHK("erased", exp_rd(a, 1'h0), v)
        wr_reg(IRQ_ENABLE_OFF, 32'h7);
        irq_en = 3'h7;
        $display("test reset done");
        d = 16'($urandom);
        prog(a, d);
        rd_reg(STATUS_OFF, v);
        `CHK("busy", 1'h0, v[STAT_DEV_READY_BIT])
        wr_reg(CMD_OFF, 32'h1);
        wait_irq(IRQ_REFUSED_BIT);
        rd_word(a, v);
        rd_word(a, v);
        `CHK("polling", ~d[7], v[7])
        rd_reg(STATUS_OFF, v);
        `CHK("toggle", 1'h1, v[STAT_TOGGLE_BIT])
        wr_reg(CTRL_OFF, 32'h1 << CTRL_BUSY_WRITE_BIT);
        op(CMD_WRITE_BIT, a, 16'h00b0);
        wait_irq(IRQ_DONE_BIT);
        settle;
        settle;
        rd_reg(STATUS_OFF, v);
        `CHK("suspended", 1'h1, v[STAT_DEV_READY_BIT])
        wait_irq(IRQ_READY_BIT);
        a2 = a ^ 24'h010005;
        rd_word(a2, v);
        `CHK("other sector", exp_rd(a2, 1'h0), v)
        op(CMD_WRITE_BIT, a, 16'h0030);
        wait_irq(IRQ_DONE_BIT);
        wr_reg(CTRL_OFF, 32'h0);
        rd_reg(STATUS_OFF, v);
        `CHK("resumed", 1'h0, v[STAT_DEV_READY_BIT])
        op(CMD_WAIT_BIT, a, d);
        wait_irq(IRQ_DONE_BIT);
        rd_word(a, v);
        `CHK("programmed", exp_rd(a, 1'h0), v)
        $display("test program done");
        wr_reg(CTRL_OFF, 32'h1);
        for (int i = 0; i < 2; i++) begin
            a2 = {a[22:0], i[0]};
            rd_word(a2, v);
            `CHK("byte", exp_rd(a2, 1'h1), v)
            `CHK("width pin", 1'h0, byte_n_out)
        end
        wr_reg(CTRL_OFF, 32'h2);
        settle;
        `CHK("protect", 1'h0, protect_accel_n_out)
        op(CMD_WRITE_BIT, a ^ 24'h000006, 16'h0000);
        wait_irq(IRQ_DONE_BIT);
        wr_reg(CTRL_OFF, 32'h0);
        settle;
        `CHK("unprotect", 1'h1, protect_accel_n_out)
        op(CMD_WAIT_BIT, a, d);
        wait_irq(IRQ_DONE_BIT);
        rd_word(a ^ 24'h000006, v);
        `CHK("protected", exp_rd(a ^ 24'h000006, 1'h0), v)
        $display("test width done");
        prog(a ^ 24'h000003, 16'h0f0f);
        op(CMD_RESET_BIT, a, d);
        wait_irq(IRQ_DONE_BIT);
        settle;
        settle;
        rd_reg(STATUS_OFF, v);
        `CHK("reset ready", 1'h1, v[STAT_DEV_READY_BIT])
        $display("test reset pulse done");
        // Busy time from prompt to slow
        for (int n = 0; n < 6; n++) begin
            busy_ns = 16'h0064 + 16'($urandom_range(1900));
            a = {1'h0, 23'($urandom)};
            prog(a, 16'($urandom));
            op(CMD_WAIT_BIT, a, d);
            wait_irq(IRQ_DONE_BIT);
            rd_word(a, v);
            `CHK("random", exp_rd(a, 1'h0), v)
        end
        $display("test random done");
        close_out;
    end
endmodule : tb_fl_host_ctrl
